// ===== core/sre_eeprom_slave.sv
// Purpose: i2c eeprom slave, byte writes and sequential reads of 512 bytes
// Assumes: scl and sda are raw pins; sda is open drain, driven low only
// Notes: write busy window shortened in simulation through WRITE_CYC
`timescale 1ns/100ps
`default_nettype none
module sre_eeprom_slave #(
   parameter int WRITE_CYC = sre_pkg::WRITE_CYC_DEF,
   parameter logic [1:0] CHIP_SEL = 2'h0
)(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclIn,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   output logic writeBusy
);
   import sre_pkg::*;

   localparam int BUSY_W = $clog2(WRITE_CYC + 1);

   if (WRITE_CYC < 1)
   begin : gBadParam
      $error("sre_eeprom_slave: WRITE_CYC must be at least 1");
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and spike filters
   wire logic [1:0] pinIn;
   assign pinIn = {sdaIn, sclIn};

   for (genvar g = 0; g < 2; g++)
   begin : gFilt
      logic [2:0] syn_r;
      logic [3:0] cnt_r;
      logic filt_r;
      wire logic differ;
      // stage 0 feeds only stage 1; stages 1 and 2 must agree
      assign differ = (syn_r[1] == syn_r[2]) && (syn_r[2] != filt_r);
      always_ff @(posedge core_clk or posedge rst)
      begin
         if (rst)
         begin
            syn_r <= 3'h7;
            cnt_r <= 4'h0;
            filt_r <= 1'b1;
         end
         else
         begin
            syn_r <= {syn_r[1:0], pinIn[g]};
            if (!differ)
               cnt_r <= 4'h0; // RULE7
            else if (cnt_r == 4'(STABLE_N - 1))
            begin
               filt_r <= syn_r[2]; // RULE7
               cnt_r <= 4'h0;
            end
            else
               cnt_r <= cnt_r + 4'h1;
         end
      end
   end

   wire logic sclF;
   wire logic sdaF;
   assign sclF = gFilt[0].filt_r;
   assign sdaF = gFilt[1].filt_r;

   ////////////////////////////////////////////////////////////////////////////
   // bus events
   logic sclPrev_r;
   logic sdaPrev_r;
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         sclPrev_r <= 1'b1;
         sdaPrev_r <= 1'b1;
      end
      else
      begin
         sclPrev_r <= sclF;
         sdaPrev_r <= sdaF;
      end
   end

   wire logic sclRise;
   wire logic sclFall;
   wire logic startEv;
   wire logic stopEv;
   assign sclRise = sclF && !sclPrev_r;
   assign sclFall = !sclF && sclPrev_r;
   assign startEv = sclF && sclPrev_r && sdaPrev_r && !sdaF;
   assign stopEv = sclF && sclPrev_r && !sdaPrev_r && sdaF;

   ////////////////////////////////////////////////////////////////////////////
   // transfer state machine
   sre_state_e state_r;
   logic [3:0] bitCnt_r;
   logic [7:0] shReg_r;
   logic [ADDR_W-1:0] addr_r;
   logic rw_r;
   logic ackBit_r;
   logic wrPend_r;
   logic sdaOeN_r;
   logic sdaOut_r;
   logic busy_r;
   logic [BUSY_W-1:0] busyCnt_r;
   logic [7:0] memQ;

   wire logic byteDone;
   wire logic devMatch;
   wire logic memWe;
   wire logic [ADDR_W-1:0] addrNxt;
   assign byteDone = sclFall && (bitCnt_r == BYTE_BITS);
   assign devMatch = (shReg_r[7:4] == CTRL_CODE) && (shReg_r[3:2] == CHIP_SEL) && !busy_r;
   assign memWe = (state_r == SRE_WRDATA) && byteDone;
   // natural 9-bit rollover takes 0x1ff to zero
   assign addrNxt = addr_r + 9'h1; // RULE3

   sre_mem #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .DEPTH(MEM_DEPTH)) u_mem (
      .clk(core_clk),
      .wrEn(memWe),
      .wrAddr(addr_r),
      .wrData(shReg_r),
      .rdAddr(addr_r), // RULE8
      .rdData(memQ)
   );

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         state_r <= SRE_IDLE;
         bitCnt_r <= 4'h0;
         shReg_r <= 8'h00;
         addr_r <= 9'h000;
         rw_r <= 1'b0;
         ackBit_r <= 1'b1;
         wrPend_r <= 1'b0;
         sdaOeN_r <= 1'b1;
      end
      else if (startEv)
      begin
         state_r <= SRE_DEVADDR;
         bitCnt_r <= CNT_ZERO;
         sdaOeN_r <= 1'b1;
      end
      else if (stopEv)
      begin
         state_r <= SRE_IDLE;
         sdaOeN_r <= 1'b1; // RULE5
         wrPend_r <= 1'b0;
      end
      else
      begin
         case (state_r)
            SRE_DEVADDR, SRE_WORDADDR, SRE_WRDATA:
            begin
               if (sclRise)
               begin
                  shReg_r <= {shReg_r[6:0], sdaF};
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
               else if (byteDone)
               begin
                  bitCnt_r <= CNT_ZERO;
                  if (state_r == SRE_DEVADDR)
                  begin
                     if (devMatch)
                     begin
                        sdaOeN_r <= 1'b0;
                        rw_r <= shReg_r[0];
                        // current-address read keeps the whole pointer
                        if (!shReg_r[0])
                           addr_r[8] <= shReg_r[1]; // RULE1
                        state_r <= SRE_ACKDEV;
                     end
                     else
                        state_r <= SRE_IDLE;
                  end
                  else if (state_r == SRE_WORDADDR)
                  begin
                     addr_r[7:0] <= shReg_r; // RULE1
                     sdaOeN_r <= 1'b0;
                     state_r <= SRE_ACKWORD;
                  end
                  else
                  begin
                     addr_r <= addrNxt;
                     wrPend_r <= 1'b1;
                     sdaOeN_r <= 1'b0;
                     state_r <= SRE_ACKWR;
                  end
               end
            end
            SRE_ACKDEV:
            begin
               if (sclFall && rw_r)
               begin
                  shReg_r <= memQ; // RULE1
                  sdaOeN_r <= memQ[7];
                  bitCnt_r <= CNT_ZERO;
                  state_r <= SRE_RD;
               end
               else if (sclFall)
               begin
                  sdaOeN_r <= 1'b1;
                  state_r <= SRE_WORDADDR;
               end
            end
            SRE_ACKWORD, SRE_ACKWR:
            begin
               if (sclFall)
               begin
                  sdaOeN_r <= 1'b1;
                  state_r <= SRE_WRDATA;
               end
            end
            SRE_RD:
            begin
               if (sclFall && bitCnt_r == LAST_BIT)
               begin
                  sdaOeN_r <= 1'b1;
                  // pointer moves now so the next byte is fetched in time
                  addr_r <= addrNxt; // RULE2 RULE8
                  state_r <= SRE_RDACK;
               end
               else if (sclFall)
               begin
                  shReg_r <= {shReg_r[6:0], 1'b0};
                  sdaOeN_r <= shReg_r[6];
                  bitCnt_r <= bitCnt_r + 4'h1;
               end
            end
            SRE_RDACK:
            begin
               if (sclRise)
                  ackBit_r <= sdaF;
               else if (sclFall && !ackBit_r)
               begin
                  shReg_r <= memQ; // RULE2 RULE4
                  sdaOeN_r <= memQ[7];
                  bitCnt_r <= CNT_ZERO;
                  state_r <= SRE_RD;
               end
               else if (sclFall)
                  state_r <= SRE_WAITSTOP; // RULE5
            end
            default:
            begin
               sdaOeN_r <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // internal write time; device refuses its address while busy
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         busy_r <= 1'b0;
         busyCnt_r <= '0;
         sdaOut_r <= 1'b0;
      end
      else if (stopEv && wrPend_r)
      begin
         busy_r <= 1'b1; // RULE6
         busyCnt_r <= BUSY_W'(WRITE_CYC - 1);
      end
      else if (busy_r && busyCnt_r == '0)
         busy_r <= 1'b0; // RULE6
      else if (busy_r)
         busyCnt_r <= busyCnt_r - 1'b1;
   end

   assign sdaOut = sdaOut_r;
   assign sdaOeN = sdaOeN_r;
   assign writeBusy = busy_r;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cbMain @(posedge core_clk); endclocking
   default disable iff (rst);

   property p_firstByte;
      (state_r == SRE_ACKDEV && sclFall && rw_r && !startEv && !stopEv)
         |=> (state_r == SRE_RD) && (shReg_r == $past(memQ)) && (sdaOeN_r == shReg_r[7]);
   endproperty
   a_firstByte: assert property (p_firstByte) else $error("first read byte not loaded"); // RULE1

   property p_ackLowNext;
      (state_r == SRE_RDACK && sclFall && !ackBit_r)
         |=> (state_r == SRE_RD) && (bitCnt_r == CNT_ZERO);
   endproperty
   a_ackLowNext: assert property (p_ackLowNext) else $error("ack low did not resume read"); // RULE2

   property p_addrStep;
      (state_r == SRE_RD && sclFall && bitCnt_r == LAST_BIT && !startEv && !stopEv)
         |=> addr_r == 9'($past(addr_r) + 9'h1);
   endproperty
   a_addrStep: assert property (p_addrStep) else $error("read address did not step"); // RULE2

   property p_wrap;
      (state_r == SRE_RD && sclFall && bitCnt_r == LAST_BIT && addr_r == LAST_ADDR)
         |=> addr_r == 9'h000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("address did not wrap to zero"); // RULE3

   property p_wrapGoesOn;
      (state_r == SRE_RDACK && addr_r == 9'h000 && sclFall && !ackBit_r && !stopEv)
         |=> state_r == SRE_RD ##1 (state_r == SRE_RD);
   endproperty
   a_wrapGoesOn: assert property (p_wrapGoesOn) else $error("read stopped after wrap"); // RULE4

   property p_nackEnd;
      (state_r == SRE_RDACK && sclFall && ackBit_r)
         |=> (state_r == SRE_WAITSTOP) && sdaOeN_r;
   endproperty
   a_nackEnd: assert property (p_nackEnd) else $error("nack did not end the read"); // RULE5

   property p_stopRelease;
      stopEv |=> sdaOeN_r && (state_r == SRE_IDLE);
   endproperty
   a_stopRelease: assert property (p_stopRelease) else $error("sda held after stop"); // RULE5

   property p_busyStart;
      (stopEv && wrPend_r) |=> busy_r && (busyCnt_r == BUSY_W'(WRITE_CYC - 1));
   endproperty
   a_busyStart: assert property (p_busyStart) else $error("write time not started"); // RULE6

   property p_busyEnd;
      (busy_r && busyCnt_r == '0 && !stopEv) |=> !busy_r;
   endproperty
   a_busyEnd: assert property (p_busyEnd) else $error("write time overran"); // RULE6

   property p_sclFilter;
      $changed(sclF) |-> $past(gFilt[0].cnt_r) == 4'(STABLE_N - 1);
   endproperty
   a_sclFilter: assert property (p_sclFilter) else $error("scl spike passed filter"); // RULE7

   property p_sdaFilter;
      $changed(sdaF) |-> $past(gFilt[1].cnt_r) == 4'(STABLE_N - 1);
   endproperty
   a_sdaFilter: assert property (p_sdaFilter) else $error("sda spike passed filter"); // RULE7

   c_wrapRead: cover property (state_r == SRE_RD && sclFall && addr_r == LAST_ADDR);
   c_nackEnd: cover property (state_r == SRE_WAITSTOP ##[1:100] stopEv);
   c_writeDone: cover property ($fell(busy_r));
   c_randomRead: cover property (state_r == SRE_ACKWORD ##[1:400] startEv);
endmodule : sre_eeprom_slave
`default_nettype wire

// ===== core/sre_mem.sv
// Purpose: byte array of the eeprom, one write port, registered read
// Assumes: single clock, write and read may hit the same address
// Notes: read data shows the old byte on a same-cycle write
`timescale 1ns/100ps
`default_nettype none
module sre_mem #(
   parameter int DATA_W = sre_pkg::DATA_W,
   parameter int ADDR_W = sre_pkg::ADDR_W,
   parameter int DEPTH = sre_pkg::MEM_DEPTH
)(
   input wire logic clk,
   input wire logic wrEn,
   input wire logic [ADDR_W-1:0] wrAddr,
   input wire logic [DATA_W-1:0] wrData,
   input wire logic [ADDR_W-1:0] rdAddr,
   output logic [DATA_W-1:0] rdData
);
   import sre_pkg::*;

   if (DEPTH != (1 << ADDR_W))
   begin : gBadDepth
      $error("sre_mem: DEPTH must equal 2**ADDR_W");
   end

   logic [DATA_W-1:0] mem [DEPTH];

   // no reset: array contents are the stored data, not control state
   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         mem[wrAddr] <= wrData;
      end
      rdData <= mem[rdAddr];
   end
endmodule : sre_mem
`default_nettype wire

// ===== core/sre_pkg.sv
// Purpose: shared constants and types for the serial eeprom read slave
// Assumes: core_clk at 100 MHz, scl and sda arrive as raw pins
// Notes: timing counts are derived here from the printed times
//
// What this block does
// (RULE1) sequential read starts from a current-address or a random-address read
// (RULE2) master ack low after a byte: increment address, send next byte
// (RULE3) incrementing past the last location 0x1ff wraps the address to zero
// (RULE4) the sequential read keeps going across the wrap, no new addressing
// (RULE5) master ack high then stop ends the read; device releases data line
// (RULE6) internal write finishes within 10 ms counted from the closing stop
// (RULE7) scl and sda pulses of 50 ns or less are never taken as activity
// (RULE8) one 9-bit address counter serves current-address and sequential reads
`default_nettype none
package sre_pkg;
   localparam int CLK_NS = 10;
   localparam int SPIKE_NS = 50;
   // a pulse must outlast the spike window by two whole samples to count
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int STABLE_N = SPIKE_CYC + 1;
   localparam int WRITE_MS = 10;
   localparam int WRITE_CYC_DEF = (WRITE_MS * 1000000) / CLK_NS;
   localparam int ADDR_W = 9;
   localparam int DATA_W = 8;
   localparam int MEM_DEPTH = 512;
   localparam logic [8:0] LAST_ADDR = 9'h1ff;
   localparam logic [3:0] CTRL_CODE = 4'ha;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] CNT_ZERO = 4'h0;

   typedef enum logic [3:0] {
      SRE_IDLE = 4'b0000,
      SRE_DEVADDR = 4'b0001,
      SRE_ACKDEV = 4'b0010,
      SRE_WORDADDR = 4'b0011,
      SRE_ACKWORD = 4'b0100,
      SRE_WRDATA = 4'b0101,
      SRE_ACKWR = 4'b0110,
      SRE_RD = 4'b0111,
      SRE_RDACK = 4'b1000,
      SRE_WAITSTOP = 4'b1001
   } sre_state_e;
endpackage : sre_pkg
`default_nettype wire

// ===== tb/serial_eeprom_sequential_read_bench.sv
// Purpose: self-checking bench of the eeprom slave against an i2c master model
// Assumes: open-drain sda with pull-up, resolved here from both parties
// Notes: scl half period 400 ns, far longer than the 70 ns the input filter needs to pass a level
`timescale 1ns/100ps
`default_nettype none
module serial_eeprom_sequential_read_bench;
   import sre_pkg::*;
   localparam int WCYC = 3000;
   logic core_clk;
   logic rst;
   logic sclDrv;
   logic sdaRel;
   logic sdaOut;
   logic sdaOeN;
   logic writeBusy;
   logic sdaWire;
   int n_mismatch;
   int n_compared;
   assign sdaWire = sdaRel & (sdaOeN | sdaOut);
   sre_eeprom_slave #(.WRITE_CYC(WCYC), .CHIP_SEL(2'h0)) i_dut (
      .core_clk(core_clk), .rst(rst), .sclIn(sclDrv), .sdaIn(sdaWire),
      .sdaOut(sdaOut), .sdaOeN(sdaOeN), .writeBusy(writeBusy));
   sre_i2c_master #(.HALF(40)) i_master (
      .core_clk(core_clk), .sdaWire(sdaWire), .sclDrv(sclDrv), .sdaRel(sdaRel));
   initial
   begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic send(input logic [7:0] d, output logic a);
      logic [7:0] q;
      i_master.byte_io(d, 1'b1, q, a);
   endtask : send
   task automatic get(input logic ackBit, output logic [7:0] d);
      logic a;
      i_master.byte_io(8'hff, ackBit, d, a);
   endtask : get
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset();
      check(8'(sdaOeN), 8'h01);
      check(8'(writeBusy), 8'h00);
   endtask : t_reset
   // wrong control code and wrong chip bits get no acknowledge
   task automatic t_refuse();
      logic [7:0] bad [2];
      logic a;
      bad = '{8'h60, 8'ha4};
      foreach (bad[i])
      begin
         i_master.start();
         send(bad[i], a);
         check(8'(a), 8'h01);
         i_master.stop();
      end
   endtask : t_refuse
   // five bytes from 0x1fe, crossing the top into 0x000 to 0x002
   task automatic t_write();
      logic [7:0] dat [5];
      logic a;
      int cnt;
      dat = '{8'h5a, 8'ha5, 8'h3c, 8'hc3, 8'h96};
      i_master.start();
      send(8'ha2, a);
      check(8'(a), 8'h00);
      send(8'hfe, a);
      check(8'(a), 8'h00);
      foreach (dat[i])
      begin
         send(dat[i], a);
         check(8'(a), 8'h00);
      end
      i_master.stop();
      i_master.wt(3);
      check(8'(writeBusy), 8'h01);
      // addressing while the array is busy is refused
      i_master.start();
      send(8'ha0, a);
      check(8'(a), 8'h01);
      i_master.stop();
      cnt = 0;
      while (writeBusy === 1'b1 && cnt < 2 * WCYC)
      begin
         @(posedge core_clk);
         cnt++;
      end
      if (cnt >= 2 * WCYC)
      begin
         n_mismatch++;
         complete_run();
      end
      check(8'(cnt <= WCYC), 8'h01);
   endtask : t_write
   // random read at 0x1fe, acked past the wrap so the stream goes on through 0x000 and 0x001
   task automatic t_seq();
      logic a;
      logic [7:0] d;
      int lowN;
      i_master.start();
      send(8'ha2, a);
      send(8'hfe, a);
      i_master.start();
      send(8'ha1, a);
      check(8'(a), 8'h00);
      get(1'b0, d);
      check(d, 8'h5a);
      get(1'b0, d);
      check(d, 8'ha5);
      get(1'b0, d);
      check(d, 8'h3c);
      get(1'b1, d);
      check(d, 8'hc3);
      i_master.stop();
      lowN = 0;
      repeat (200)
      begin
         @(posedge core_clk);
         lowN += (sdaOeN === 1'b1) ? 0 : 1;
      end
      check(8'(lowN), 8'h00);
   endtask : t_seq
   // current-address read picks up at 0x002 with 40 ns scl glitches in every bit
   task automatic t_cur();
      logic a;
      logic [7:0] d;
      i_master.glitchN = 4;
      i_master.start();
      send(8'ha1, a);
      check(8'(a), 8'h00);
      get(1'b1, d);
      check(d, 8'h96);
      i_master.stop();
      i_master.glitchN = 0;
   endtask : t_cur
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      n_mismatch = 0;
      n_compared = 0;
      rst = 1'b1;
      repeat (8) @(posedge core_clk);
      rst <= 1'b0;
      repeat (20) @(posedge core_clk);
      t_reset();
      t_refuse();
      t_write();
      t_seq();
      t_cur();
      complete_run();
   end
endmodule : serial_eeprom_sequential_read_bench
`default_nettype wire

// ===== tb/sre_i2c_master.sv
// Purpose: i2c bus master driving scl and the master side of sda
// Assumes: half periods of HALF core_clk cycles; scl stands high between frames
// Notes: glitchN adds a short low pulse in the scl high phase of every bit, not in start or stop
`timescale 1ns/100ps
`default_nettype none
module sre_i2c_master #(
   parameter int HALF = 40
)(
   input wire logic core_clk,
   input wire logic sdaWire,
   output var logic sclDrv,
   output var logic sdaRel
);
   int glitchN;
   initial
   begin
      sclDrv = 1'b1;
      sdaRel = 1'b1;
      glitchN = 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic wt(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wt
   // data set mid low phase, wire sampled at the end of the high phase
   task automatic bit_io(input logic b, output logic s);
      wt(HALF / 2);
      sdaRel <= b;
      wt(HALF / 2);
      sclDrv <= 1'b1;
      wt(HALF / 2);
      if (glitchN > 0)
      begin
         sclDrv <= 1'b0;
         wt(glitchN);
         sclDrv <= 1'b1;
      end
      wt(HALF / 2);
      s = sdaWire;
      sclDrv <= 1'b0;
   endtask : bit_io
   // also serves as repeated start, as the random read needs
   task automatic start();
      sdaRel <= 1'b1;
      wt(HALF / 2);
      sclDrv <= 1'b1;
      wt(HALF);
      sdaRel <= 1'b0;
      wt(HALF);
      sclDrv <= 1'b0;
   endtask : start
   task automatic stop();
      wt(HALF / 2);
      sdaRel <= 1'b0;
      wt(HALF / 2);
      sclDrv <= 1'b1;
      wt(HALF);
      sdaRel <= 1'b1;
      wt(HALF);
   endtask : stop
   // a write sends d and releases the ack slot; a read releases d, drives ackBit
   task automatic byte_io(input logic [7:0] d, input logic ackBit, output logic [7:0] q,
      output logic ackSeen);
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], q[i]);
      bit_io(ackBit, ackSeen);
   endtask : byte_io
endmodule : sre_i2c_master
`default_nettype wire
